/* File: csr_pkg.sv */
// Constants, types and helpers shared by the lane receiver files.
// Assumes LP lines are sampled as {dp, dn} pairs; no software registers exist.
package csr_pkg;

	// Low-power line codes, written as {dp, dn}
	localparam logic [1:0] LP_STOP   = 2'h3;
	localparam logic [1:0] LP_RQST   = 2'h1;
	localparam logic [1:0] LP_BRIDGE = 2'h0;

	// Lane and word geometry
	localparam int LANES      = 4;
	localparam int BYTE_W     = 8;
	localparam int CNT_W      = 2;
	localparam int WORD_W     = BYTE_W * LANES + CNT_W + 1;
	localparam int WORD_CNT_LSB = BYTE_W * LANES;
	localparam int WORD_SOF_BIT = WORD_W - 1;

	// Lane count selection codes
	localparam logic [1:0] CFG_LANES_1 = 2'h0;
	localparam logic [1:0] CFG_LANES_2 = 2'h1;

	// Location of the clock mode bit in the device map; here it is a pin
	localparam logic [7:0] CONT_CLK_CFG_ADDR = 8'h02;
	localparam int         CONT_CLK_CFG_BIT  = 6;

	// Packet layout
	localparam int         DT_W         = 6;
	localparam int         WC_W         = 16;
	localparam logic [5:0] DT_SHORT_MAX = 6'h0F;
	localparam logic [1:0] HDR_LAST     = 2'h3;
	localparam logic [1:0] HDR_WC_LO    = 2'h1;
	localparam logic [1:0] HDR_WC_HI    = 2'h2;
	localparam logic [1:0] HDR_ID       = 2'h0;

	// Lane control states
	typedef enum logic [2:0] {LS_INIT, LS_STOP, LS_RQST, LS_HS, LS_ESC} csr_lane_state_t;

	// Packet parser states
	typedef enum logic [1:0] {PS_HDR, PS_PAY, PS_FOOT} csr_parse_state_t;

	// Last byte index of a word for a lane count selection
	function automatic logic [1:0] last_index(input logic [1:0] cfg);
		logic [1:0] r;
		r = 2'h3;
		if (cfg == CFG_LANES_1)
		begin
			r = 2'h0;
		end
		else if (cfg == CFG_LANES_2)
		begin
			r = 2'h1;
		end
		return r;
	endfunction : last_index

endpackage : csr_pkg

/* File: csr_stream_if.sv */
// Valid/ready word carrier between the crossing, buffer and parser.
// Assumes both ends sit on the system clock.
`timescale 1ns/10ps
interface csr_stream_if;
	logic                         valid;
	logic                         ready;
	logic [csr_pkg::WORD_W-1:0]   data;

	// Producer end
	modport src (output valid, output data, input ready);
	// Consumer end
	modport snk (input valid, input data, output ready);
endinterface : csr_stream_if

/* File: csr_lane_fsm.sv */
// Low-power state tracking and termination control for one lane.
// Assumes raw LP pins from outside the clock domain; syncs them itself.
`timescale 1ns/10ps
module csr_lane_fsm (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// Control
	input  wire logic enable_i,
	input  wire logic hold_i,
	// LP pins
	input  wire logic lp_dp_i,
	input  wire logic lp_dn_i,
	// Termination enable, high during a burst
	output logic      term_en_o
);
	logic [1:0]               meta_q;
	logic [1:0]               lp_q;
	csr_pkg::csr_lane_state_t state_q;
	csr_pkg::csr_lane_state_t state_d;
	logic                     term_q;

	// Two-flop sampling of the LP pins
	always_ff @(posedge clk_i)
	begin
		meta_q <= {lp_dp_i, lp_dn_i};
		lp_q   <= meta_q;
	end

	// Next state; receive only, nothing ever drives the lane [RULE9]
	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			csr_pkg::LS_INIT:   if (lp_q == csr_pkg::LP_STOP) state_d = csr_pkg::LS_STOP; // [RULE1]
			csr_pkg::LS_STOP:
			begin
				if (lp_q == csr_pkg::LP_RQST)
					state_d = csr_pkg::LS_RQST; // [RULE2]
				else if (lp_q != csr_pkg::LP_STOP)
					state_d = csr_pkg::LS_ESC; // Escape or bad entry ignored [RULE10]
			end
			csr_pkg::LS_RQST:
			begin
				if (lp_q == csr_pkg::LP_BRIDGE)
					state_d = csr_pkg::LS_HS; // [RULE2] [RULE7]
				else if (lp_q == csr_pkg::LP_STOP)
					state_d = csr_pkg::LS_STOP;
				else if (lp_q != csr_pkg::LP_RQST)
					state_d = csr_pkg::LS_ESC;
			end
			csr_pkg::LS_HS:     if (lp_q == csr_pkg::LP_STOP && !hold_i) state_d = csr_pkg::LS_STOP; // [RULE3] [RULE6]
			csr_pkg::LS_ESC:    if (lp_q == csr_pkg::LP_STOP) state_d = csr_pkg::LS_STOP; // [RULE10]
		endcase
		if (!enable_i)
			state_d = csr_pkg::LS_INIT;
	end

	// State and termination registers
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			state_q <= csr_pkg::LS_INIT;
			term_q  <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			term_q  <= (state_d == csr_pkg::LS_HS); // [RULE4] [RULE7]
		end
	end

	assign term_en_o = term_q;

	property p_hs_entry;
		@(posedge clk_i) disable iff (!rst_n_i)
		$rose(term_q) |-> $past(state_q) == csr_pkg::LS_RQST && $past(lp_q) == csr_pkg::LP_BRIDGE;
	endproperty
	a_hs_entry: assert property (p_hs_entry) else $error("burst entered without LP-01 then LP-00"); // [RULE2]

	property p_hs_stays;
		@(posedge clk_i) disable iff (!rst_n_i)
		term_q && enable_i && lp_q != csr_pkg::LP_STOP |=> term_q;
	endproperty
	a_hs_stays: assert property (p_hs_stays) else $error("burst left without stop state"); // [RULE3]

	property p_hs_exit;
		@(posedge clk_i) disable iff (!rst_n_i)
		term_q && lp_q == csr_pkg::LP_STOP && !hold_i |=> !term_q;
	endproperty
	a_hs_exit: assert property (p_hs_exit) else $error("stop state did not end burst"); // [RULE4]

	property p_cont_hold;
		@(posedge clk_i) disable iff (!rst_n_i)
		term_q && hold_i && enable_i |=> term_q;
	endproperty
	a_cont_hold: assert property (p_cont_hold) else $error("continuous clock lane left HS"); // [RULE6]

	property p_escape;
		@(posedge clk_i) disable iff (!rst_n_i)
		state_q == csr_pkg::LS_STOP && enable_i && lp_q == 2'h2 |=> state_q == csr_pkg::LS_ESC ##1 !term_q;
	endproperty
	a_escape: assert property (p_escape) else $error("escape entry was not ignored"); // [RULE10]

endmodule : csr_lane_fsm

/* File: csr_buf2.sv */
// Two-entry word buffer with valid/ready on both sides.
// Assumes producer and consumer share the system clock.
`timescale 1ns/10ps
module csr_buf2 (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// Streams
	csr_stream_if.snk in_if,
	csr_stream_if.src out_if
);
	logic [csr_pkg::WORD_W-1:0] mem_q [2];
	logic [csr_pkg::WORD_W-1:0] mem_d [2];
	logic                       wr_q, wr_d, rd_q, rd_d;
	logic [1:0]                 cnt_q, cnt_d;
	logic                       push, pop;

	// Handshakes and pointer updates
	always_comb
	begin
		push  = in_if.valid && (cnt_q != 2'h2);
		pop   = out_if.ready && (cnt_q != 2'h0);
		mem_d = mem_q;
		if (push)
			mem_d[wr_q] = in_if.data;
		wr_d  = push ? !wr_q : wr_q;
		rd_d  = pop ? !rd_q : rd_q;
		cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
	end

	// Storage registers
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			wr_q  <= 1'b0;
			rd_q  <= 1'b0;
			cnt_q <= 2'h0;
		end
		else
		begin
			wr_q  <= wr_d;
			rd_q  <= rd_d;
			cnt_q <= cnt_d;
		end
		mem_q <= mem_d;
	end

	assign in_if.ready  = (cnt_q != 2'h2);
	assign out_if.valid = (cnt_q != 2'h0);
	assign out_if.data  = mem_q[rd_q];

	property p_no_overfill;
		@(posedge clk_i) disable iff (!rst_n_i)
		cnt_q == 2'h2 && !out_if.ready |=> cnt_q == 2'h2 && !in_if.ready;
	endproperty
	a_no_overfill: assert property (p_no_overfill) else $error("full buffer changed without a pop");

endmodule : csr_buf2

/* File: csr_lane_receiver.sv */
// Top of the camera-serial lane receiver: lane control, byte merge, packet parse.
// Assumes byte_clk_i comes from the clock lane and may stop between bursts.
//
// What this block does
// RULE1: Every burst starts from and returns to the LP-11 stop state.
// RULE2: Only the ordered LP-11, LP-01, LP-00 sequence enters high-speed mode.
// RULE3: After entry a lane stays in high-speed mode until LP-11 is seen.
// RULE4: Termination is enabled for the whole burst, with LP lines expected at LP-00.
// RULE5: A configuration input selects continuous or non-continuous clock lane mode.
// RULE6: In continuous mode the clock lane stays in high-speed mode for good.
// RULE7: The clock lane uses the same entry, termination and exit as data lanes.
// RULE8: One, two or four data lanes may be active beside the clock lane.
// RULE9: Lanes are receive only; nothing is driven back and there is no turnaround.
// RULE10: Escape mode is not supported and its traffic is ignored.
// RULE11: A packet whose data type is 0x00 to 0x0F is a short packet.
// RULE12: The sensor signals frame and line starts in short packets before long payload.
// RULE13: A long packet has a 4-byte header, word-count payload bytes and a 2-byte footer.
// RULE14: With several lanes, bytes are taken round robin starting at lane zero.
`timescale 1ns/10ps
module csr_lane_receiver (
	// System clock and reset
	input  wire logic                           clk_i,
	input  wire logic                           rst_n_i,
	// Configuration
	input  wire logic [1:0]                     lane_cfg_i,
	input  wire logic                           cont_clk_i,
	// LP pins
	input  wire logic                           clk_lp_dp_i,
	input  wire logic                           clk_lp_dn_i,
	input  wire logic [csr_pkg::LANES-1:0]      lp_dp_i,
	input  wire logic [csr_pkg::LANES-1:0]      lp_dn_i,
	// High-speed link, byte clock domain
	input  wire logic                           byte_clk_i,
	input  wire logic [csr_pkg::BYTE_W*csr_pkg::LANES-1:0] hs_byte_i,
	input  wire logic [csr_pkg::LANES-1:0]      hs_valid_i,
	// Termination enables
	output logic                                clk_term_en_o,
	output logic [csr_pkg::LANES-1:0]           term_en_o,
	// Packet header report
	output logic                                pkt_start_o,
	output logic                                pkt_short_o,
	output logic [csr_pkg::DT_W-1:0]            pkt_dt_o,
	output logic [csr_pkg::WC_W-1:0]            pkt_wc_o,
	// Payload stream
	output logic                                pay_valid_o,
	output logic [csr_pkg::BYTE_W-1:0]          pay_data_o,
	output logic                                pay_last_o,
	input  wire logic                           out_ready_i,
	// Lost word flag
	output logic                                overflow_o
);
	// Lane control, system domain
	logic [csr_pkg::LANES-1:0] lane_en;
	logic                      clk_term;
	logic [csr_pkg::LANES-1:0] term;

	// Enable lanes up to the selected count
	always_comb
	begin
		for (int i = 0; i < csr_pkg::LANES; i++)
			lane_en[i] = (2'(i) <= csr_pkg::last_index(lane_cfg_i)); // [RULE8]
	end

	// Clock lane, held in HS when continuous mode is selected
	csr_lane_fsm u_clk_lane (
		.clk_i     (clk_i),
		.rst_n_i   (rst_n_i),
		.enable_i  (rst_n_i), // Always on once out of reset
		.hold_i    (cont_clk_i), // [RULE5] [RULE6]
		.lp_dp_i   (clk_lp_dp_i),
		.lp_dn_i   (clk_lp_dn_i),
		.term_en_o (clk_term)
	);

	// Data lanes
	for (genvar g = 0; g < csr_pkg::LANES; g++)
	begin : g_lane
		csr_lane_fsm u_lane (
			.clk_i     (clk_i),
			.rst_n_i   (rst_n_i),
			.enable_i  (lane_en[g]),
			.hold_i    (!lane_en[g]), // Data lanes never hold HS; enable wins when off
			.lp_dp_i   (lp_dp_i[g]),
			.lp_dn_i   (lp_dn_i[g]),
			.term_en_o (term[g])
		);
	end

	assign clk_term_en_o = clk_term;
	assign term_en_o     = term;

	// Byte clock domain state
	logic                       lrst_meta_q, lrst_q;
	logic [1:0]                 cfg_meta_q, cfg_q;
	logic [csr_pkg::LANES-1:0]  act_meta_q, act_q;
	logic                       ack_meta_q, ack_q;
	logic                       req_meta_q, req_sync_q, seen_q, seen_d;
	logic [csr_pkg::WORD_W-1:0] lw_q, lw_d;
	logic                       req_q, req_d;
	logic                       first_q, first_d;
	logic                       ovf_tgl_q, ovf_tgl_d;
	logic                       capture;
	logic                       busy;
	logic [csr_pkg::BYTE_W*csr_pkg::LANES-1:0] masked;

	// Level crossings into the byte clock domain
	always_ff @(posedge byte_clk_i)
	begin
		lrst_meta_q <= rst_n_i;
		lrst_q      <= lrst_meta_q;
		cfg_meta_q  <= lane_cfg_i;
		cfg_q       <= cfg_meta_q;
		act_meta_q  <= term;
		act_q       <= act_meta_q;
		ack_meta_q  <= seen_q;
		ack_q       <= ack_meta_q;
	end

	// Word capture, lane zero in the low byte
	always_comb
	begin
		capture = act_q[0] && hs_valid_i[0];
		busy    = (req_q != ack_q);
		for (int i = 0; i < csr_pkg::LANES; i++)
		begin
			if (2'(i) <= csr_pkg::last_index(cfg_q)) // [RULE8]
				masked[i*csr_pkg::BYTE_W +: csr_pkg::BYTE_W] = hs_byte_i[i*csr_pkg::BYTE_W +: csr_pkg::BYTE_W]; // [RULE14]
			else
				masked[i*csr_pkg::BYTE_W +: csr_pkg::BYTE_W] = 8'h00;
		end
		lw_d      = lw_q;
		req_d     = req_q;
		ovf_tgl_d = ovf_tgl_q;
		first_d   = act_q[0] ? (capture ? 1'b0 : first_q) : 1'b1; // [RULE1]
		if (capture && !busy)
		begin
			lw_d  = {first_q, csr_pkg::last_index(cfg_q), masked};
			req_d = !req_q;
		end
		else if (capture)
			ovf_tgl_d = !ovf_tgl_q;
	end

	// Byte clock domain registers
	always_ff @(posedge byte_clk_i)
	begin
		if (!lrst_q)
		begin
			lw_q      <= '0;
			req_q     <= 1'b0;
			first_q   <= 1'b1;
			ovf_tgl_q <= 1'b0;
		end
		else
		begin
			lw_q      <= lw_d;
			req_q     <= req_d;
			first_q   <= first_d;
			ovf_tgl_q <= ovf_tgl_d;
		end
	end

	// System domain crossing and buffer
	csr_stream_if xfer_if ();
	csr_stream_if drain_if ();
	logic ovf_meta_q, ovf_sync_q, ovf_seen_q, ovf_q, ovf_d;

	// Toggle crossings into the system domain, cleared so no unknown toggle lands
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			req_meta_q <= 1'b0;
			req_sync_q <= 1'b0;
			ovf_meta_q <= 1'b0;
			ovf_sync_q <= 1'b0;
		end
		else
		begin
			req_meta_q <= req_q;
			req_sync_q <= req_meta_q;
			ovf_meta_q <= ovf_tgl_q;
			ovf_sync_q <= ovf_meta_q;
		end
	end

	// Push a new word once its request toggle arrives
	always_comb
	begin
		xfer_if.valid = (req_sync_q != seen_q);
		xfer_if.data  = lw_q;
		seen_d        = (xfer_if.valid && xfer_if.ready) ? req_sync_q : seen_q;
		ovf_d         = ovf_q || (ovf_sync_q != ovf_seen_q);
	end

	csr_buf2 u_buf (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.in_if   (xfer_if),
		.out_if  (drain_if)
	);

	// Parser state, system domain
	logic [csr_pkg::WORD_W-1:0] uw_q, uw_d;
	logic                       have_q, have_d;
	logic [1:0]                 bi_q, bi_d;
	csr_pkg::csr_parse_state_t  ps_q, ps_d;
	logic [1:0]                 hb_q, hb_d;
	logic [csr_pkg::WC_W-1:0]   rem_q, rem_d;
	logic                       foot_q, foot_d;
	logic [csr_pkg::DT_W-1:0]   dt_q, dt_d;
	logic [csr_pkg::BYTE_W-1:0] wlo_q, wlo_d;
	logic                       st_q, st_d, sh_q, sh_d;
	logic [csr_pkg::DT_W-1:0]   pdt_q, pdt_d;
	logic [csr_pkg::WC_W-1:0]   pwc_q, pwc_d, wc;
	logic                       pv_q, pv_d, pl_q, pl_d;
	logic [csr_pkg::BYTE_W-1:0] pd_q, pd_d, b;
	logic                       consume, last_b, short_dt;

	// Unpack words into bytes and walk the packet layout
	always_comb
	begin
		consume  = have_q && !(pv_q && !out_ready_i);
		b        = uw_q[bi_q*csr_pkg::BYTE_W +: csr_pkg::BYTE_W];
		last_b   = (bi_q == uw_q[csr_pkg::WORD_CNT_LSB +: csr_pkg::CNT_W]);
		wc       = {b, wlo_q};
		short_dt = (dt_q <= csr_pkg::DT_SHORT_MAX); // [RULE11]
		drain_if.ready = !have_q || (consume && last_b);
		uw_d   = uw_q;
		have_d = have_q;
		bi_d   = bi_q;
		ps_d   = ps_q;
		hb_d   = hb_q;
		rem_d  = rem_q;
		foot_d = foot_q;
		dt_d   = dt_q;
		wlo_d  = wlo_q;
		st_d   = 1'b0;
		sh_d   = sh_q;
		pdt_d  = pdt_q;
		pwc_d  = pwc_q;
		pv_d   = pv_q && !out_ready_i;
		pl_d   = pl_q;
		pd_d   = pd_q;
		if (consume)
		begin
			bi_d = bi_q + 2'h1;
			uw_d[csr_pkg::WORD_SOF_BIT] = 1'b0;
			if (last_b)
				have_d = 1'b0;
			// A new burst always restarts at a header
			if (uw_q[csr_pkg::WORD_SOF_BIT] || ps_q == csr_pkg::PS_HDR) // [RULE1]
			begin
				hb_d = (uw_q[csr_pkg::WORD_SOF_BIT] ? 2'h0 : hb_q) + 2'h1;
				ps_d = csr_pkg::PS_HDR;
				unique case (uw_q[csr_pkg::WORD_SOF_BIT] ? csr_pkg::HDR_ID : hb_q)
					csr_pkg::HDR_ID:    dt_d  = b[csr_pkg::DT_W-1:0];
					csr_pkg::HDR_WC_LO: wlo_d = b;
					csr_pkg::HDR_WC_HI: pwc_d = wc;
					csr_pkg::HDR_LAST:
					begin
						st_d  = 1'b1;
						sh_d  = short_dt; // [RULE11]
						pdt_d = dt_q;
						rem_d = pwc_q; // Count locates the footer [RULE13]
						foot_d = 1'b0;
						if (!short_dt)
							ps_d = (pwc_q == 16'h0000) ? csr_pkg::PS_FOOT : csr_pkg::PS_PAY;
					end
				endcase
			end
			else if (ps_q == csr_pkg::PS_PAY)
			begin
				pv_d  = 1'b1;
				pd_d  = b;
				pl_d  = (rem_q == 16'h0001);
				rem_d = rem_q - 16'h0001;
				if (rem_q == 16'h0001)
					ps_d = csr_pkg::PS_FOOT; // [RULE13]
			end
			else
			begin
				foot_d = 1'b1;
				if (foot_q)
				begin
					ps_d = csr_pkg::PS_HDR; // Two checksum bytes skipped
					hb_d = 2'h0;
				end
			end
		end
		if (drain_if.valid && drain_if.ready)
		begin
			uw_d   = drain_if.data;
			have_d = 1'b1;
			bi_d   = 2'h0;
		end
	end

	// System domain registers
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			seen_q     <= 1'b0;
			ovf_seen_q <= 1'b0;
			ovf_q      <= 1'b0;
			uw_q       <= '0;
			have_q     <= 1'b0;
			bi_q       <= 2'h0;
			ps_q       <= csr_pkg::PS_HDR;
			hb_q       <= 2'h0;
			rem_q      <= 16'h0000;
			foot_q     <= 1'b0;
			dt_q       <= 6'h00;
			wlo_q      <= 8'h00;
			st_q       <= 1'b0;
			sh_q       <= 1'b0;
			pdt_q      <= 6'h00;
			pwc_q      <= 16'h0000;
			pv_q       <= 1'b0;
			pl_q       <= 1'b0;
			pd_q       <= 8'h00;
		end
		else
		begin
			seen_q     <= seen_d;
			ovf_seen_q <= ovf_sync_q;
			ovf_q      <= ovf_d;
			uw_q       <= uw_d;
			have_q     <= have_d;
			bi_q       <= bi_d;
			ps_q       <= ps_d;
			hb_q       <= hb_d;
			rem_q      <= rem_d;
			foot_q     <= foot_d;
			dt_q       <= dt_d;
			wlo_q      <= wlo_d;
			st_q       <= st_d;
			sh_q       <= sh_d;
			pdt_q      <= pdt_d;
			pwc_q      <= pwc_d;
			pv_q       <= pv_d;
			pl_q       <= pl_d;
			pd_q       <= pd_d;
		end
	end

	// Registered outputs
	assign pkt_start_o = st_q;
	assign pkt_short_o = sh_q;
	assign pkt_dt_o    = pdt_q;
	assign pkt_wc_o    = pwc_q;
	assign pay_valid_o = pv_q;
	assign pay_data_o  = pd_q;
	assign pay_last_o  = pl_q;
	assign overflow_o  = ovf_q;

	property p_short_class;
		@(posedge clk_i) disable iff (!rst_n_i)
		st_q |-> sh_q == (pdt_q <= csr_pkg::DT_SHORT_MAX);
	endproperty
	a_short_class: assert property (p_short_class) else $error("short packet misclassified"); // [RULE11]

	property p_footer_after_last;
		@(posedge clk_i) disable iff (!rst_n_i)
		pv_q && pl_q && out_ready_i |-> ps_q == csr_pkg::PS_FOOT;
	endproperty
	a_footer_after_last: assert property (p_footer_after_last) else $error("no footer after last byte"); // [RULE13]

	property p_stall_hold;
		@(posedge clk_i) disable iff (!rst_n_i)
		pv_q && !out_ready_i |=> pv_q && $stable(pd_q) && $stable(pl_q);
	endproperty
	a_stall_hold: assert property (p_stall_hold) else $error("payload byte lost under stall");

	property p_lane_order;
		@(posedge byte_clk_i) disable iff (!lrst_q)
		capture && !busy |=> lw_q[7:0] == $past(hs_byte_i[7:0]);
	endproperty
	a_lane_order: assert property (p_lane_order) else $error("lane zero byte not first"); // [RULE14]

	property p_lane_mask;
		@(posedge byte_clk_i) disable iff (!lrst_q)
		capture && !busy && cfg_q == csr_pkg::CFG_LANES_1 |=> lw_q[31:8] == 24'h000000;
	endproperty
	a_lane_mask: assert property (p_lane_mask) else $error("inactive lane bytes taken"); // [RULE8]

	c_short:   cover property (@(posedge clk_i) disable iff (!rst_n_i) st_q && sh_q);
	c_long:    cover property (@(posedge clk_i) disable iff (!rst_n_i) pv_q && pl_q);
	c_stall:   cover property (@(posedge clk_i) disable iff (!rst_n_i) pv_q && !out_ready_i ##1 pv_q);
	c_fourln:  cover property (@(posedge byte_clk_i) disable iff (!lrst_q) capture && cfg_q == 2'h2);

endmodule : csr_lane_receiver

/* File: csr_sensor_model.sv */
// Sensor side model: LP lines, gated byte clock and HS words.
// Assumes clk_i is the receiver's system clock; lanes only ever face the receiver.
`timescale 1ns/10ps
module csr_sensor_model (
	// System clock
	input  wire logic   clk_i,
	// Lane lines, driven one way only
	output logic        byte_clk_o,
	output logic        clk_dp_o,
	output logic        clk_dn_o,
	output logic [3:0]  dp_o,
	output logic [3:0]  dn_o,
	output logic [31:0] hs_byte_o,
	output logic [3:0]  hs_valid_o
);
	logic               run = 1'b1;

	// Idle lines in stop state
	initial
	begin
		byte_clk_o = 1'b0;
		{clk_dp_o, clk_dn_o} = csr_pkg::LP_STOP;
		dp_o = 4'hF;
		dn_o = 4'hF;
		hs_byte_o = 32'h0;
		hs_valid_o = 4'h0;
	end

	// Byte clock stands still between bursts, once hs_end has stopped it; it runs from time zero
	always #15 byte_clk_o = run ? ~byte_clk_o : 1'b0;

	// Data lanes to dc, clock lane to cc, for n cycles
	task automatic lp_set(input logic [1:0] dc, input logic [1:0] cc, input int n);
		@(posedge clk_i);
		dp_o <= {4{dc[1]}};
		dn_o <= {4{dc[0]}};
		clk_dp_o <= cc[1];
		clk_dn_o <= cc[0];
		repeat (n - 1) @(posedge clk_i);
		#1;
	endtask : lp_set

	// Ordered entry, no escape request ever
	task automatic hs_begin();
		lp_set(csr_pkg::LP_STOP, csr_pkg::LP_STOP, 4);
		lp_set(csr_pkg::LP_RQST, csr_pkg::LP_RQST, 4);
		lp_set(csr_pkg::LP_BRIDGE, csr_pkg::LP_BRIDGE, 8);
		run = 1'b1;
	endtask : hs_begin

	// Data lanes stop while the clock still runs, then clock stops and clock lane stops
	task automatic hs_end();
		repeat (4) @(posedge byte_clk_o);
		lp_set(csr_pkg::LP_STOP, csr_pkg::LP_BRIDGE, 12);
		run = 1'b0;
		lp_set(csr_pkg::LP_STOP, csr_pkg::LP_STOP, 6);
	endtask : hs_end

	// One word on every 9th byte clock, changing junk between
	task automatic send(input logic [31:0] w);
		repeat (7) @(posedge byte_clk_o) hs_byte_o <= ~hs_byte_o;
		@(posedge byte_clk_o);
		hs_byte_o <= w;
		hs_valid_o <= 4'hF;
		@(posedge byte_clk_o);
		hs_valid_o <= 4'h0;
		hs_byte_o <= ~w;
	endtask : send
endmodule : csr_sensor_model

/* File: csr_lane_receiver_tb_top.sv */
// Bench for the lane receiver: LP entry and exit, lane merge, packet parse.
// Assumes the sensor model drives every lane and the byte clock.
`timescale 1ns/10ps
`define CHK(a, b) \
	begin checks++; if ((a) !== (b)) begin err_count++; \
	$display("[FAIL] %0t %h %h", $time, (a), (b)); end end
module csr_lane_receiver_tb_top;
	logic        clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic [1:0]  lane_cfg_i = 2'h2;
	logic        cont_clk_i = 1'b0;
	logic        out_ready_i = 1'b1;
	logic        byte_clk, clk_dp, clk_dn, clk_term_en_o;
	logic [3:0]  dp, dn, hs_valid, term_en_o;
	logic [31:0] hs_byte;
	logic        pkt_start_o, pkt_short_o, pay_valid_o, pay_last_o, overflow_o;
	logic [5:0]  pkt_dt_o;
	logic [15:0] pkt_wc_o;
	logic [7:0]  pay_data_o;
	logic [22:0] pk_q;
	logic [8:0]  payq[$];
	int          err_count = 0;
	int          checks = 0;
	int          pk_n = 0;

	always #10 clk_i = ~clk_i;

	// Sensor model and receiver
	csr_sensor_model sen (.clk_i(clk_i), .byte_clk_o(byte_clk), .clk_dp_o(clk_dp),
		.clk_dn_o(clk_dn), .dp_o(dp), .dn_o(dn), .hs_byte_o(hs_byte), .hs_valid_o(hs_valid));
	csr_lane_receiver uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .lane_cfg_i(lane_cfg_i),
		.cont_clk_i(cont_clk_i), .clk_lp_dp_i(clk_dp), .clk_lp_dn_i(clk_dn), .lp_dp_i(dp),
		.lp_dn_i(dn), .byte_clk_i(byte_clk), .hs_byte_i(hs_byte), .hs_valid_i(hs_valid),
		.clk_term_en_o(clk_term_en_o), .term_en_o(term_en_o), .pkt_start_o(pkt_start_o),
		.pkt_short_o(pkt_short_o), .pkt_dt_o(pkt_dt_o), .pkt_wc_o(pkt_wc_o),
		.pay_valid_o(pay_valid_o), .pay_data_o(pay_data_o), .pay_last_o(pay_last_o),
		.out_ready_i(out_ready_i), .overflow_o(overflow_o));

	// Log headers and accepted payload bytes
	always @(posedge clk_i)
	begin
		if (pkt_start_o === 1'b1)
		begin
			pk_n++;
			pk_q = {pkt_short_o, pkt_dt_o, pkt_wc_o};
		end
		if ((pay_valid_o & out_ready_i) === 1'b1)
			payq.push_back({pay_last_o, pay_data_o});
	end

	// Verdict and end of run
	task automatic report_and_stop();
		if (err_count == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop

	// Bounded wait for np headers and nb bytes
	task automatic wait_for(input int np, input int nb);
		int i;
		for (i = 0; i < 3000 && (pk_n < np || payq.size() < nb); i++)
			@(posedge clk_i);
		if (pk_n < np || payq.size() < nb)
		begin
			err_count++;
			report_and_stop();
		end
	endtask : wait_for

	// Payload is b0, b0+1, ..., last flag on the final byte
	task automatic chk_pay(input logic [7:0] b0, input int n);
		int i;
		`CHK(payq.size(), n)
		for (i = 0; i < n; i++)
			`CHK(payq[i], {i == n - 1, b0 + 8'(i)})
	endtask : chk_pay

	// Refused entries, good entry, hold, exit
	task automatic t_lp();
		`CHK({overflow_o, pay_valid_o, clk_term_en_o, term_en_o}, 7'h00)
		sen.lp_set(csr_pkg::LP_STOP, csr_pkg::LP_STOP, 6);
		sen.lp_set(csr_pkg::LP_BRIDGE, csr_pkg::LP_BRIDGE, 8);
		`CHK({clk_term_en_o, term_en_o}, 5'h00)
		sen.lp_set(csr_pkg::LP_STOP, csr_pkg::LP_STOP, 6);
		sen.lp_set(2'h2, 2'h2, 8);
		`CHK({clk_term_en_o, term_en_o}, 5'h00)
		sen.hs_begin();
		`CHK({clk_term_en_o, term_en_o}, 5'h1F)
		sen.lp_set(csr_pkg::LP_BRIDGE, csr_pkg::LP_BRIDGE, 30);
		`CHK({clk_term_en_o, term_en_o}, 5'h1F)
		sen.hs_end();
		`CHK({clk_term_en_o, term_en_o}, 5'h00)
	endtask : t_lp

	// Continuous clock lane keeps its termination
	task automatic t_cont();
		@(posedge clk_i) cont_clk_i <= 1'b1;
		sen.hs_begin();
		sen.lp_set(csr_pkg::LP_BRIDGE, csr_pkg::LP_STOP, 8);
		`CHK({clk_term_en_o, term_en_o}, 5'h1F)
		sen.hs_end();
		`CHK({clk_term_en_o, term_en_o}, 5'h10)
		@(posedge clk_i) cont_clk_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		#1;
		`CHK(clk_term_en_o, 1'b0)
	endtask : t_cont

	// One lane long packet, byte per word
	task automatic t_one();
		int i;
		int np;
		logic [7:0] b[9] = '{8'h2A, 8'h03, 8'h00, 8'hEE, 8'h10, 8'h11, 8'h12, 8'hC1, 8'hC2};
		@(posedge clk_i) lane_cfg_i <= csr_pkg::CFG_LANES_1;
		payq.delete();
		np = pk_n;
		sen.hs_begin();
		`CHK(term_en_o, 4'h1)
		for (i = 0; i < 9; i++)
			sen.send({24'hA5A5A5, b[i]});
		wait_for(np + 1, 3);
		`CHK(pk_q, {1'b0, 6'h2A, 16'h0003})
		chk_pay(8'h10, 3);
		sen.hs_end();
	endtask : t_one

	// Two lanes, lane zero byte first
	task automatic t_two();
		int np;
		@(posedge clk_i) lane_cfg_i <= csr_pkg::CFG_LANES_2;
		payq.delete();
		np = pk_n;
		sen.hs_begin();
		`CHK(term_en_o, 4'h3)
		sen.send(32'hA5A50224);
		sen.send(32'hA5A57700);
		sen.send(32'hA5A53130);
		sen.send(32'hA5A5F2F1);
		wait_for(np + 1, 2);
		`CHK(pk_q, {1'b0, 6'h24, 16'h0002})
		chk_pay(8'h30, 2);
		sen.hs_end();
	endtask : t_two

	// Four lanes, data types across the short/long edge
	task automatic t_short();
		int i;
		int np;
		logic [5:0] dt[4] = '{6'h00, 6'h0F, 6'h10, 6'h3F};
		@(posedge clk_i) lane_cfg_i <= 2'h2;
		for (i = 0; i < 4; i++)
		begin
			np = pk_n;
			sen.hs_begin();
			sen.send({8'h5A, 8'h12, 8'h34, 2'h1, dt[i]});
			wait_for(np + 1, 0);
			`CHK(pk_q, {dt[i] <= 6'h0F, dt[i], 16'h1234})
			sen.hs_end();
		end
	endtask : t_short

	// Four lanes with the sink stalled, nothing lost
	task automatic t_four();
		int np;
		@(posedge clk_i) out_ready_i <= 1'b0;
		payq.delete();
		np = pk_n;
		sen.hs_begin();
		sen.send(32'hEE00062B);
		sen.send(32'h23222120);
		sen.send(32'hF2F12524);
		repeat (40) @(posedge clk_i);
		#1;
		`CHK({pay_valid_o, pay_data_o}, 9'h120)
		@(posedge clk_i) out_ready_i <= 1'b1;
		wait_for(np + 1, 6);
		`CHK(pk_q, {1'b0, 6'h2B, 16'h0006})
		chk_pay(8'h20, 6);
		`CHK(overflow_o, 1'b0)
		sen.hs_end();
	endtask : t_four

	// Main sequence
	initial
	begin
		repeat (5) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		#1;
		t_lp();
		t_cont();
		t_one();
		t_two();
		t_short();
		t_four();
		report_and_stop();
	end
endmodule : csr_lane_receiver_tb_top
